/* hw/wdog_pkg.sv */
package wdog_pkg;

    // ****************************************
    // bus map (byte addresses, word aligned)
    // ****************************************
    localparam logic [15:0] SERVICE_IDX      = 16'hffff;  // printed offset, kept as an index
    localparam logic [31:0] SERVICE_ADDR     = {14'h0000, SERVICE_IDX, 2'h0};
    localparam logic [31:0] SYSOPT_ADDR      = 32'h0000_0040;
    localparam logic [31:0] CAUSE_ADDR       = 32'h0000_0044;
    localparam logic [31:0] STATUS_ADDR      = 32'h0000_0048;
    localparam logic [31:0] BREAK_AUX_ADDR   = 32'h0000_004c;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int          OPT_WDOG_DIS_BIT = 0;
    localparam int          OPT_HALT_EN_BIT  = 1;
    localparam int          OPT_SHORT_REC_BIT = 3;
    localparam int          OPT_RST_PIN_BIT  = 4;
    localparam int          OPT_TSEL_BIT     = 5;
    localparam logic [7:0]  SYSOPT_RESET     = 8'h00;
    localparam int          CAUSE_WDOG_BIT   = 0;
    localparam int          BRK_DIS_BIT      = 0;
    localparam int          STAT_HALTED_BIT  = 8;
    localparam int          STAT_POR_BIT     = 9;
    localparam int          STAT_ACTIVE_BIT  = 10;

    // ****************************************
    // cycle counts of the oscillator clock
    // ****************************************
    localparam logic [17:0] LONG_TIMEOUT     = 18'd262128;
    localparam logic [17:0] SHORT_TIMEOUT    = 18'd8176;
    localparam logic [4:0]  RST_PULSE_LAST   = 5'd31;     // 32 cycles
    localparam logic [11:0] LONG_REC_LAST    = 12'd4095;  // 4096 cycles
    localparam logic [11:0] SHORT_REC_LAST   = 12'd31;    // 32 cycles
    localparam logic [11:0] POR_LAST         = 12'd4095;  // 4096 cycles
    localparam logic [7:0]  PRESC_KEEP_MASK  = 8'h00;     // stages 12..5 forced low

    // ****************************************
    // halt sequencer
    // ****************************************
    typedef enum logic [2:0] {
        ST_RUN     = 3'b001,
        ST_HALTED  = 3'b010,
        ST_RECOVER = 3'b100
    } halt_state_t;

endpackage : wdog_pkg

/* hw/watchdog_reset_timer.sv */
// Notes on behaviour
// - 6-bit watchdog counter clocked through a 12-bit prescaler.
// - overflow raises reset after 262128 or 8176 clocks per timeout select.
// - any write to service address clears counter and prescaler stages 12..5.
// - reading the service address returns the reset vector low byte.
// - watchdog reset drives reset pin low 32 clocks if enabled, sets cause flag.
// - halt clears the prescaler; the watchdog clock stops while halted.
// - after power-up the prescaler is cleared 4096 clocks later.
// - any internal reset clears prescaler and watchdog counter.
// - disable option 1 stops the watchdog, 0 lets it run.
// - no watchdog in monitor mode while test high voltage is present.
// - watchdog keeps counting in wait mode; software must service it.
// - break in monitor mode with break disable bit set stops the watchdog.
// - watchdog never requests an interrupt, only a reset.
// - halt exit after 32 clocks with short recovery set, else 4096.
// - halt exit by low-voltage reset always takes the long recovery.
// - halt enable 0 makes halt an illegal opcode, 1 executes it.
// - timeout select 1 picks 8176 cycles, 0 picks 262128 cycles.
module watchdog_reset_timer
    import wdog_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic [7:0]  reset_vector_lo,
    input  wire logic        halt_exec,
    input  wire logic        halt_wake,
    input  wire logic        low_voltage_reset,
    input  wire logic        internal_reset,
    input  wire logic        monitor_mode,
    input  wire logic        test_high_voltage,
    input  wire logic        break_active,
    output logic             wdog_reset,
    output logic             reset_pin_out,
    output logic             reset_pin_oe,
    output logic             halted,
    output logic             illegal_opcode
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [11:0] presc;
        logic [5:0]  wcount;
        logic [11:0] por_cnt;
        logic        por_busy;
        halt_state_t hstate;
        logic [11:0] rec_cnt;
        logic        rec_long;
        logic [4:0]  pulse_cnt;
        logic        rst_active;
        logic        rst_pin_oe;
        logic        cause_wdog;
        logic [7:0]  sysopt;
        logic        opt_locked;
        logic        brk_dis;
        logic        vtst_s1;
        logic        vtst_s2;
        logic        vtst_s3;
        logic        vtst;
        logic        dp_write;
        logic        dp_valid;
        logic [31:0] dp_addr;
        logic [31:0] rdata;
        logic        illegal;
    } state_t;

    state_t s_q;
    state_t s_d;

    localparam state_t STATE_RESET = '{
        presc:      12'h000,
        wcount:     6'h00,
        por_cnt:    12'h000,
        por_busy:   1'b1,
        hstate:     ST_RUN,
        rec_cnt:    12'h000,
        rec_long:   1'b0,
        pulse_cnt:  5'h00,
        rst_active: 1'b0,
        rst_pin_oe: 1'b0,
        cause_wdog: 1'b0,
        sysopt:     SYSOPT_RESET,
        opt_locked: 1'b0,
        brk_dis:    1'b0,
        vtst_s1:    1'b0,
        vtst_s2:    1'b0,
        vtst_s3:    1'b0,
        vtst:       1'b0,
        dp_write:   1'b0,
        dp_valid:   1'b0,
        dp_addr:    32'h0000_0000,
        rdata:      32'h0000_0000,
        illegal:    1'b0
    };

    // ****************************************
    // combinational helpers
    // ****************************************
    logic        addr_phase;
    logic        wr_service;
    logic        wr_sysopt;
    logic        wr_cause;
    logic        wr_break;
    logic        active;
    logic [17:0] elapsed;
    logic [17:0] limit;
    logic        overflow;
    logic        clear_all;
    logic [31:0] rd_word;

    // a transfer is taken only when the previous one has completed
    assign addr_phase = hsel & htrans[1] & hready;

    // writes land in the data phase, when hwdata is on the bus
    assign wr_service = s_q.dp_valid & s_q.dp_write & (s_q.dp_addr == SERVICE_ADDR);
    assign wr_sysopt  = s_q.dp_valid & s_q.dp_write & (s_q.dp_addr == SYSOPT_ADDR);
    assign wr_cause   = s_q.dp_valid & s_q.dp_write & (s_q.dp_addr == CAUSE_ADDR);
    assign wr_break   = s_q.dp_valid & s_q.dp_write & (s_q.dp_addr == BREAK_AUX_ADDR);

    // watchdog clock gating: halt and disable stop it; in monitor mode, test voltage and break (with break disable set) stop it too
    assign active = ~s_q.sysopt[OPT_WDOG_DIS_BIT]
                  & ~(monitor_mode & s_q.vtst)
                  & ~(break_active & monitor_mode & s_q.brk_dis)
                  & (s_q.hstate == ST_RUN)
                  & ~s_q.por_busy
                  & ~s_q.rst_active;

    // the pair acts as one 18-bit count: counter steps on prescaler carry
    assign elapsed = {s_q.wcount, s_q.presc};
    assign limit   = s_q.sysopt[OPT_TSEL_BIT] ? SHORT_TIMEOUT : LONG_TIMEOUT;
    assign overflow = active & (elapsed == (limit - 18'd1));

    // internal and low-voltage resets, plus the watchdog's own reset
    assign clear_all = internal_reset | low_voltage_reset | overflow | s_q.rst_active;

    // read mux, looked up in the address phase so data stands in the data phase
    always_comb begin
        rd_word = 32'h0000_0000;
        case (haddr)
            SERVICE_ADDR:   rd_word = {24'h000000, reset_vector_lo};
            SYSOPT_ADDR:    rd_word = {24'h000000, s_q.sysopt};
            CAUSE_ADDR:     rd_word = {31'h00000000, s_q.cause_wdog};
            BREAK_AUX_ADDR: rd_word = {31'h00000000, s_q.brk_dis};
            STATUS_ADDR: begin
                rd_word[5:0]             = s_q.wcount;
                rd_word[STAT_HALTED_BIT] = (s_q.hstate != ST_RUN);
                rd_word[STAT_POR_BIT]    = s_q.por_busy;
                rd_word[STAT_ACTIVE_BIT] = active;
            end
            default:        rd_word = 32'h0000_0000;
        endcase
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d = s_q;

        // test voltage pin: three stages, accepted once the last two agree
        s_d.vtst_s1 = test_high_voltage;
        s_d.vtst_s2 = s_q.vtst_s1;
        s_d.vtst_s3 = s_q.vtst_s2;
        if (s_q.vtst_s2 == s_q.vtst_s3) begin
            s_d.vtst = s_q.vtst_s3;
        end

        // bus address phase; zero wait states, so always ready
        s_d.dp_valid = addr_phase;
        s_d.dp_write = hwrite;
        s_d.dp_addr  = haddr;
        s_d.rdata    = (addr_phase & ~hwrite) ? rd_word : 32'h0000_0000;

        // options take one write per reset; later writes are ignored
        if (wr_sysopt & ~s_q.opt_locked) begin
            s_d.sysopt     = hwdata[7:0];
            s_d.opt_locked = 1'b1;
        end
        if (wr_break) begin
            s_d.brk_dis = hwdata[BRK_DIS_BIT];
        end

        // power-up delay before the prescaler is released
        if (s_q.por_busy) begin
            if (s_q.por_cnt == POR_LAST) begin
                s_d.por_busy = 1'b0;
                s_d.presc    = 12'h000;
            end else begin
                s_d.por_cnt = s_q.por_cnt + 12'd1;
            end
        end

        // counting; wait mode has no input here, so counting goes on
        if (active) begin
            {s_d.wcount, s_d.presc} = elapsed + 18'd1;
        end

        // service write: low four prescaler stages survive the clear
        if (wr_service) begin
            s_d.wcount      = 6'h00;
            s_d.presc[11:4] = PRESC_KEEP_MASK;
        end

        // timeout fires a reset, never an interrupt
        if (overflow) begin
            s_d.rst_active = 1'b1;
            s_d.rst_pin_oe = s_q.sysopt[OPT_RST_PIN_BIT];
            s_d.pulse_cnt  = 5'h00;
        end else if (s_q.rst_active) begin
            if (s_q.pulse_cnt == RST_PULSE_LAST) begin
                s_d.rst_active = 1'b0;
                s_d.rst_pin_oe = 1'b0;
            end else begin
                s_d.pulse_cnt = s_q.pulse_cnt + 5'd1;
            end
        end

        // cause flag: write one to clear, a new timeout wins over the clear
        if (wr_cause & hwdata[CAUSE_WDOG_BIT]) begin
            s_d.cause_wdog = 1'b0;
        end
        if (overflow) begin
            s_d.cause_wdog = 1'b1;
        end

        if (clear_all) begin
            s_d.presc  = 12'h000;
            s_d.wcount = 6'h00;
        end

        // halt sequencer
        s_d.illegal = 1'b0;
        case (s_q.hstate)
            ST_RUN: begin
                if (halt_exec) begin
                    if (s_q.sysopt[OPT_HALT_EN_BIT]) begin
                        s_d.hstate = ST_HALTED;
                        s_d.presc  = 12'h000;
                    end else begin
                        s_d.illegal = 1'b1;
                    end
                end
            end
            ST_HALTED: begin
                if (halt_wake | low_voltage_reset) begin
                    s_d.hstate   = ST_RECOVER;
                    s_d.rec_cnt  = 12'h000;
                    // low-voltage exit ignores the short option
                    s_d.rec_long = low_voltage_reset
                                 | ~s_q.sysopt[OPT_SHORT_REC_BIT];
                end
            end
            ST_RECOVER: begin
                if (low_voltage_reset) begin
                    s_d.rec_long = 1'b1;
                end
                if (s_q.rec_cnt == (s_q.rec_long ? LONG_REC_LAST : SHORT_REC_LAST)) begin
                    s_d.hstate = ST_RUN;
                end else begin
                    s_d.rec_cnt = s_q.rec_cnt + 12'd1;
                end
            end
            default: begin
                s_d.hstate = ST_RUN;
            end
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    // one flop bank; asynchronous reset loads constants only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    logic hreadyout_q;
    logic hresp_q;
    logic reset_pin_out_q;
    logic halted_q;

    // constant answers still come from flops so outputs are clean
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q     <= 1'b1;
            hresp_q         <= 1'b0;
            reset_pin_out_q <= 1'b0;
            halted_q        <= 1'b0;
        end else begin
            hreadyout_q     <= 1'b1;
            hresp_q         <= 1'b0;
            reset_pin_out_q <= 1'b0;   // open drain: only ever pulls low
            halted_q        <= (s_d.hstate != ST_RUN);
        end
    end

    assign hreadyout      = hreadyout_q;
    assign hresp          = hresp_q;
    assign hrdata         = s_q.rdata;
    assign wdog_reset     = s_q.rst_active;
    assign reset_pin_out  = reset_pin_out_q;
    assign reset_pin_oe   = s_q.rst_pin_oe;
    assign halted         = halted_q;
    assign illegal_opcode = s_q.illegal;

endmodule : watchdog_reset_timer

/* dv/watchdog_reset_timer_asserts.sv */
module watchdog_reset_timer_asserts
    import wdog_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic [7:0]  reset_vector_lo,
    input wire logic        halt_exec,
    input wire logic        halt_wake,
    input wire logic        wdog_reset,
    input wire logic        reset_pin_out,
    input wire logic        reset_pin_oe,
    input wire logic        halted,
    input wire logic        illegal_opcode
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ****************************************
    // helper: length of the reset pulse so far
    // ****************************************
    logic [5:0] pulse_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) pulse_q <= 6'h00;
        else pulse_q <= wdog_reset ? pulse_q + 6'h01 : 6'h00;
    end

    // ****************************************
    // sequences and properties
    // ****************************************
    sequence s_rd;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence s_svc_rd;
        s_rd and (haddr == SERVICE_ADDR);
    endsequence
    sequence s_halt_in;
        !halted ##1 halted;
    endsequence

    a_pulse_len: assert property ($fell(wdog_reset) |-> pulse_q == 6'h20)
        else $error("reset pulse length wrong");
    a_pulse_max: assert property (pulse_q <= 6'h20)
        else $error("reset pulse too long");
    a_pin_drive: assert property (reset_pin_oe |-> wdog_reset && !reset_pin_out)
        else $error("reset pin driven outside pulse");
    a_svc_read: assert property (s_svc_rd |=> hrdata[7:0] == $past(reset_vector_lo))
        else $error("service read not vector byte");
    a_rd_idle: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> hrdata == 32'h0000_0000)
        else $error("read data left standing");
    a_illegal_one: assert property (illegal_opcode |=> !illegal_opcode)
        else $error("illegal opcode pulse too long");
    a_illegal_src: assert property (illegal_opcode |-> $past(halt_exec) && !halted)
        else $error("illegal opcode without halt");
    a_halt_entry: assert property (s_halt_in |-> $past(halt_exec) && !illegal_opcode)
        else $error("halted without halt request");
    a_halt_quiet: assert property (halted && $past(halted) |-> !$rose(wdog_reset))
        else $error("timeout while halted");
    a_wake_hold: assert property (halted && halt_wake |=> halted [*8])
        else $error("halt recovery too short");
endmodule : watchdog_reset_timer_asserts

bind watchdog_reset_timer watchdog_reset_timer_asserts watchdog_reset_timer_asserts_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .reset_vector_lo(reset_vector_lo),
    .halt_exec(halt_exec), .halt_wake(halt_wake), .wdog_reset(wdog_reset),
    .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe), .halted(halted),
    .illegal_opcode(illegal_opcode)
);

/* dv/reset_line_model.sv */
module reset_line_model (
    input  wire logic hclk,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output logic      pin_level,
    output int        low_len
);
    timeunit 1ns;
    timeprecision 100ps;
    int run_q = 0;

    // pull-up holds the line high once released
    assign pin_level = pin_oe ? pin_out : 1'b1;

    // length of the last low stretch seen on the line
    initial low_len = 0;
    always @(posedge hclk) begin
        if (pin_level === 1'b0) run_q++;
        else if (run_q != 0) begin
            low_len = run_q;
            run_q = 0;
        end
    end
endmodule : reset_line_model

/* dv/watchdog_reset_timer_test.sv */
module watchdog_reset_timer_test import wdog_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [1:0]  htrans = 0;
    logic        halt_exec = 0, halt_wake = 0, low_voltage_reset = 0, internal_reset = 0;
    logic        monitor_mode = 0, test_high_voltage = 0, break_active = 0;
    logic        hresp, wdog_reset, reset_pin_out, reset_pin_oe, halted, illegal_opcode;
    logic        pin_level;
    int          low_len, c;
    int          n_fail = 0, n_checks = 0;

    watchdog_reset_timer watchdog_reset_timer_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .reset_vector_lo(8'h5a),
        .halt_exec(halt_exec), .halt_wake(halt_wake), .low_voltage_reset(low_voltage_reset),
        .internal_reset(internal_reset), .monitor_mode(monitor_mode),
        .test_high_voltage(test_high_voltage), .break_active(break_active),
        .wdog_reset(wdog_reset), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
        .halted(halted), .illegal_opcode(illegal_opcode));
    reset_line_model reset_line_model_i (.hclk(hclk), .pin_out(reset_pin_out),
        .pin_oe(reset_pin_oe), .pin_level(pin_level), .low_len(low_len));

    // ****************************************
    // tasks
    // ****************************************
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // master waits on hready, no fixed latency assumed
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask : bus
    task quiet(input string nm, input int n);
        int h;
        h = 0;
        repeat (n) begin
            @(posedge hclk);
            if (wdog_reset !== 1'b0) h++;
        end
        chk(nm, 0, h);
    endtask : quiet
    task pulse_halt(input logic lvr);
        @(posedge hclk);
        halt_wake <= 1'b1;
        low_voltage_reset <= lvr;
        @(posedge hclk);
        halt_wake <= 1'b0;
        low_voltage_reset <= 1'b0;
        for (c = 1; halted !== 1'b0; c++) @(posedge hclk);
    endtask : pulse_halt
    task halt_req;
        @(posedge hclk);
        halt_exec <= 1'b1;
        @(posedge hclk);
        halt_exec <= 1'b0;
    endtask : halt_req
    task results;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    // ****************************************
    // clock, watchdog and sequence
    // ****************************************
    initial forever #2 hclk = ~hclk;
    // sized for about 95k cycles; the tests take about 74k
    initial begin
        #380000;
        n_fail++;
        results();
    end
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4110) @(posedge hclk);
        bus(0, SYSOPT_ADDR, 0);
        chk("opt reset", {24'h0, SYSOPT_RESET}, r);
        bus(0, SERVICE_ADDR, 0);
        chk("svc read", 32'h5a, {24'h0, r[7:0]});
        bus(0, 32'h80, 0);
        chk("unmapped", 0, r);
        bus(1, SYSOPT_ADDR, 32'h3a);
        bus(1, SYSOPT_ADDR, 32'h00);
        bus(0, SYSOPT_ADDR, 0);
        chk("opt once", 32'h3a, r);
        // two services keep the timer away from overflow
        repeat (2) begin
            bus(1, SERVICE_ADDR, 32'h0);
            quiet("serviced", 6000);
        end
        bus(1, SERVICE_ADDR, 32'hffff_ffff);
        for (c = 0; wdog_reset !== 1'b1; c++) @(posedge hclk);
        chk("short tmo", 1, c >= SHORT_TIMEOUT - 18 && c <= SHORT_TIMEOUT + 2);
        chk("pin oe", 1, reset_pin_oe);
        repeat (40) @(posedge hclk);
        chk("pin low", 32, low_len);
        bus(0, CAUSE_ADDR, 0);
        chk("cause set", 1, r[CAUSE_WDOG_BIT]);
        bus(1, CAUSE_ADDR, 32'h1);
        bus(0, CAUSE_ADDR, 0);
        chk("cause clr", 0, r[CAUSE_WDOG_BIT]);
        // monitor mode with break, then with test voltage
        bus(1, BREAK_AUX_ADDR, 32'h1);
        monitor_mode <= 1'b1;
        break_active <= 1'b1;
        quiet("break", 8300);
        break_active <= 1'b0;
        test_high_voltage <= 1'b1;
        quiet("tst volt", 8300);
        monitor_mode <= 1'b0;
        test_high_voltage <= 1'b0;
        bus(1, SERVICE_ADDR, 0);
        halt_req();
        quiet("halted", 8300);
        chk("halt st", 1, halted);
        pulse_halt(1'b0);
        chk("short rec", 1, c >= 30 && c <= 35);
        bus(1, SERVICE_ADDR, 0);
        halt_req();
        pulse_halt(1'b1);
        chk("lv rec", 1, c >= 4090 && c <= 4100);
        internal_reset <= 1'b1;
        quiet("int reset", 8300);
        internal_reset <= 1'b0;
        // fresh power-on so the option register takes a new value
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4110) @(posedge hclk);
        bus(1, SYSOPT_ADDR, 32'h21);
        quiet("disabled", 8300);
        halt_req();
        @(posedge hclk);
        chk("illegal", 1, illegal_opcode);
        chk("no halt", 0, halted);
        results();
    end
endmodule : watchdog_reset_timer_test
